// >>> pcr_bank.sv
// peripheral control register bank with apb slave
// assumes apb master on mclk, pins synchronised here
`timescale 1ns/1ps
module pcr_bank
#(
    parameter int GPR_N = pcr_pkg::GPR_COUNT
)
(
    input  wire logic        mclk,
    input  wire logic        rst_b,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic [5:0]  p5_in,
    output logic [5:0]       p5_out,
    output logic [5:0]       p5_oe,
    input  wire logic [7:0]  p6_in,
    output logic [7:0]       p6_out,
    output logic [7:0]       p6_oe,
    input  wire logic        cmp_raw,
    input  wire logic        pulse_level,
    input  wire logic        cnt_ext_src,
    input  wire logic        power_down_instruction,
    output logic [9:0]       table_addr_bits,
    output logic             code_byte_half_select,
    output logic             pulse_gen_on,
    output logic             pw_counter_on,
    output logic [2:0]       pw_counter_divider,
    output logic [8:0]       pw_divide_ratio,
    output logic             comparator_on,
    output logic [7:0]       comparator_mode_field,
    output logic             reference_source_sel,
    output logic [2:0]       reference_level_field,
    output logic [1:0]       negative_input_channel,
    output logic             counter_clock_source,
    output logic             core_clock_select,
    output logic             idle_entered,
    output logic             sleep_entered,
    output logic             wake_request
);
    import pcr_pkg::*;

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    logic [7:0] ram_select_q, port_five_data_q, port_six_data_q;
    logic [7:0] table_pointer_low_q, table_pointer_high_q, pulse_width_control_q;
    logic [7:0] comparator_select_q, comparator_config_q, system_control_q;
    logic [7:0] wakeup_control_q, port_five_direction_q, port_six_direction_q;
    logic [7:0] gpr_q [GPR_N];
    logic [2:0] cmp_sync_q, pd_sync_q;
    logic [7:0] p6_s1_q, p6_s2_q, p6_s3_q;
    logic [5:0] p5_s1_q, p5_s2_q, p5_s3_q;
    logic       cmp_res_q;
    logic [7:0] p6_pin_q;
    logic [5:0] p5_pin_q;
    logic       pd_pin_q;
    logic       access_d;
    logic       wr_d;
    logic [5:0] idx_d;
    logic [7:0] wdat;
    logic [7:0] rdat_d;
    logic [5:0] p5_oe_d;

    pcr_pin_if pins ();
    pcr_pin_mux u_mux (.pins(pins));

    function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nw,
                                         input logic [7:0] mask);
        merge = (old & ~mask) | (nw & mask);
    endfunction : merge

    // a pin bit moves only when stages two and three agree, so a one-cycle glitch is dropped
    function automatic logic [7:0] settle(input logic [7:0] cur, input logic [7:0] s2,
                                          input logic [7:0] s3);
        settle = (s3 & ~(s2 ^ s3)) | (cur & (s2 ^ s3));
    endfunction : settle

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    always_comb
    begin
        access_d = psel && penable;
        wdat     = pwdata[7:0];
        idx_d    = paddr[7:2];
        if (idx_d == IDX_INDIRECT)
        begin
            idx_d = ram_select_q[5:0];
        end
        wr_d = access_d && pwrite && (paddr[1:0] == 2'b00);
    end

    function automatic logic mapped(input logic [5:0] i);
        mapped = (i >= GPR_FIRST) || i == IDX_RAM_SEL || i == IDX_PORT5 ||
                 i == IDX_PORT6 || i == IDX_TBL_LO || i == IDX_TBL_HI ||
                 i == IDX_PW_CTL || i == IDX_CMP_SEL || i == IDX_CMP_CFG ||
                 i == IDX_SYS_CTL || i == IDX_WAKE_CTL || i == IDX_DIR5 || i == IDX_DIR6;
    endfunction : mapped

    always_comb
    begin
        rdat_d = 8'h00;
        case (idx_d)
            IDX_RAM_SEL:  rdat_d = ram_select_q;
            IDX_PORT5:    rdat_d = {2'b00, p5_pin_q & port_five_direction_q[5:0]
                                   | port_five_data_q[5:0] & ~port_five_direction_q[5:0]};
            IDX_PORT6:    rdat_d = p6_pin_q & port_six_direction_q
                                   | port_six_data_q & ~port_six_direction_q;
            IDX_TBL_LO:   rdat_d = table_pointer_low_q;
            IDX_TBL_HI:   rdat_d = table_pointer_high_q & MASK_TBL_HI;
            IDX_PW_CTL:   rdat_d = pulse_width_control_q & MASK_PW_CTL;
            IDX_CMP_SEL:  rdat_d = comparator_select_q;
            IDX_CMP_CFG:  rdat_d = (comparator_config_q & MASK_CMP_CFG)
                                   | (8'(cmp_res_q) << BIT_CMP_RESULT);
            IDX_SYS_CTL:  rdat_d = system_control_q & MASK_SYS_CTL;
            IDX_WAKE_CTL: rdat_d = wakeup_control_q & MASK_WAKE;
            IDX_DIR5:     rdat_d = port_five_direction_q & MASK_PORT5;
            IDX_DIR6:     rdat_d = port_six_direction_q;
            default:
            begin
                if (idx_d >= GPR_FIRST)
                begin
                    rdat_d = gpr_q[idx_d - GPR_FIRST];
                end
            end
        endcase
    end

    // zero-wait slave; pready is registered from the setup cycle so it is high in the first access cycle
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pready  <= 1'b0;
            prdata  <= RD_ZERO;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel && !penable;
            if (psel && !penable)
            begin
                prdata  <= {24'h000000, rdat_d};
                pslverr <= !mapped(idx_d);
            end
        end
    end

    logic wr_go;
    assign wr_go = wr_d && pready;

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ram_select_q          <= RST_REG;
            port_five_data_q      <= RST_REG;
            port_six_data_q       <= RST_REG;
            table_pointer_low_q   <= RST_REG;
            table_pointer_high_q  <= RST_REG;
            pulse_width_control_q <= RST_REG;
            comparator_select_q   <= RST_REG;
            comparator_config_q   <= RST_REG;
            system_control_q      <= RST_REG;
            wakeup_control_q      <= RST_REG;
            port_five_direction_q <= RST_DIR;
            port_six_direction_q  <= RST_DIR;
        end
        else if (wr_go)
        begin
            case (idx_d)
                IDX_RAM_SEL:  ram_select_q          <= wdat;
                IDX_PORT5:    port_five_data_q      <= merge(port_five_data_q, wdat, MASK_PORT5);
                IDX_PORT6:    port_six_data_q       <= wdat;
                IDX_TBL_LO:   table_pointer_low_q   <= wdat;
                IDX_TBL_HI:   table_pointer_high_q  <= merge(table_pointer_high_q, wdat,
                                                             MASK_TBL_HI);
                IDX_PW_CTL:   pulse_width_control_q <= merge(pulse_width_control_q, wdat,
                                                             MASK_PW_CTL);
                IDX_CMP_SEL:  comparator_select_q   <= wdat;
                IDX_CMP_CFG:  comparator_config_q   <= merge(comparator_config_q, wdat,
                                                             MASK_CMP_CFG);
                IDX_SYS_CTL:  system_control_q      <= merge(system_control_q, wdat,
                                                             MASK_SYS_CTL);
                IDX_WAKE_CTL: wakeup_control_q      <= merge(wakeup_control_q, wdat, MASK_WAKE);
                IDX_DIR5:     port_five_direction_q <= merge(port_five_direction_q, wdat,
                                                             MASK_PORT5);
                IDX_DIR6:     port_six_direction_q  <= wdat;
                default:      ;
            endcase
        end
    end

    // general registers have no reset, like ordinary ram
    always_ff @(posedge mclk)
    begin
        if (wr_go && idx_d >= GPR_FIRST)
        begin
            gpr_q[idx_d - GPR_FIRST] <= wdat;
        end
    end

    // ----------------------------------------------------------------
    // pin synchronisers: change counts once stages two and three agree
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cmp_sync_q <= 3'b000;
            pd_sync_q  <= 3'b000;
            p6_s1_q    <= 8'h00;
            p6_s2_q    <= 8'h00;
            p6_s3_q    <= 8'h00;
            p5_s1_q    <= 6'h00;
            p5_s2_q    <= 6'h00;
            p5_s3_q    <= 6'h00;
            cmp_res_q  <= 1'b0;
            p6_pin_q   <= 8'h00;
            p5_pin_q   <= 6'h00;
            pd_pin_q   <= 1'b0;
        end
        else
        begin
            cmp_sync_q <= {cmp_sync_q[1:0], cmp_raw};
            pd_sync_q  <= {pd_sync_q[1:0], power_down_instruction};
            p6_s1_q    <= p6_in;
            p6_s2_q    <= p6_s1_q;
            p6_s3_q    <= p6_s2_q;
            p5_s1_q    <= p5_in;
            p5_s2_q    <= p5_s1_q;
            p5_s3_q    <= p5_s2_q;
            if (cmp_sync_q[1] == cmp_sync_q[2])
            begin
                cmp_res_q <= cmp_sync_q[2];
            end
            if (pd_sync_q[1] == pd_sync_q[2])
            begin
                pd_pin_q <= pd_sync_q[2];
            end
            p6_pin_q   <= settle(p6_pin_q, p6_s2_q, p6_s3_q);
            p5_pin_q   <= 6'(settle({2'b00, p5_pin_q}, {2'b00, p5_s2_q}, {2'b00, p5_s3_q}));
        end
    end

    // ----------------------------------------------------------------
    // outputs and events
    // ----------------------------------------------------------------
    logic cmp_change, port_change;
    logic [7:0] p6_prev_q;
    logic       cmp_prev_q;
    assign cmp_change  = cmp_res_q != cmp_prev_q;
    assign port_change = |((p6_pin_q ^ p6_prev_q) & port_six_direction_q);

    logic pd_prev_q;

    assign pins.p6_data    = port_six_data_q;
    assign pins.p6_dir     = port_six_direction_q;
    assign pins.cmp_sel    = comparator_select_q;
    assign pins.cmp_on     = comparator_config_q[BIT_CMP_ON];
    assign pins.ref_int    = comparator_config_q[BIT_REF_SRC];
    assign pins.neg_chan   = comparator_config_q[1:0];
    assign pins.pulse_on   = pulse_width_control_q[BIT_PULSE_ON];
    assign pins.pulse_out  = pulse_level;
    assign pins.cnt_ext    = cnt_ext_src;
    assign pins.cmp_result = cmp_res_q;

    always_comb
    begin
        p5_oe_d = ~port_five_direction_q[5:0];
        // p50 serves as negative input d when selected
        if (comparator_config_q[BIT_CMP_ON] && comparator_config_q[1:0] == 2'b11)
        begin
            p5_oe_d[0] = 1'b0;
        end
    end

    function automatic logic [8:0] ratio(input logic [2:0] code);
        case (code)
            3'b000:  ratio = 9'h001;
            3'b001:  ratio = 9'h002;
            3'b010:  ratio = 9'h004;
            3'b011:  ratio = 9'h008;
            3'b100:  ratio = 9'h010;
            3'b101:  ratio = 9'h040;
            3'b110:  ratio = 9'h080;
            default: ratio = 9'h100;
        endcase
    endfunction : ratio

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            p5_out <= 6'h00; p5_oe <= 6'h00; p6_out <= 8'h00; p6_oe <= 8'h00;
            table_addr_bits <= 10'h000; code_byte_half_select <= 1'b0;
            pulse_gen_on <= 1'b0; pw_counter_on <= 1'b0; pw_counter_divider <= 3'h0;
            pw_divide_ratio <= 9'h001; comparator_on <= 1'b0; comparator_mode_field <= 8'h00;
            reference_source_sel <= 1'b0; reference_level_field <= 3'h0;
            negative_input_channel <= 2'h0; counter_clock_source <= 1'b0;
            core_clock_select <= 1'b0; idle_entered <= 1'b0; sleep_entered <= 1'b0;
            wake_request <= 1'b0; p6_prev_q <= 8'h00; cmp_prev_q <= 1'b0; pd_prev_q <= 1'b0;
        end
        else
        begin
            p5_out <= port_five_data_q[5:0];
            p5_oe  <= p5_oe_d;
            p6_out <= pins.p6_out;
            p6_oe  <= pins.p6_oe;
            table_addr_bits       <= {table_pointer_high_q[1:0], table_pointer_low_q};
            code_byte_half_select <= table_pointer_high_q[BIT_HALF_SEL];
            pulse_gen_on          <= pulse_width_control_q[BIT_PULSE_ON];
            pw_counter_on         <= pulse_width_control_q[BIT_PW_CNT_ON];
            pw_counter_divider    <= pulse_width_control_q[2:0];
            pw_divide_ratio       <= ratio(pulse_width_control_q[2:0]);
            comparator_on         <= comparator_config_q[BIT_CMP_ON];
            comparator_mode_field <= comparator_config_q[BIT_CMP_ON] ?
                                     comparator_select_q : 8'h00;
            reference_source_sel  <= comparator_config_q[BIT_REF_SRC];
            reference_level_field <= comparator_config_q[6:4];
            negative_input_channel <= comparator_config_q[1:0];
            counter_clock_source  <= system_control_q[BIT_CNT_CLK_SRC];
            core_clock_select     <= system_control_q[BIT_CORE_CLK];
            pd_prev_q  <= pd_pin_q;
            idle_entered  <= pd_pin_q && !pd_prev_q && system_control_q[BIT_IDLE];
            sleep_entered <= pd_pin_q && !pd_prev_q && !system_control_q[BIT_IDLE];
            p6_prev_q  <= p6_pin_q;
            cmp_prev_q <= cmp_res_q;
            wake_request <= (cmp_change && wakeup_control_q[BIT_CMP_WAKE])
                          || (port_change && wakeup_control_q[BIT_PORT_WAKE]);
        end
    end
endmodule : pcr_bank

// >>> pcr_bank_checker.sv
// concurrent checks on the ports of the control register bank
// assumes binding onto every pcr_bank instance, single mclk domain
`timescale 1ns/1ps
module pcr_bank_checker
(
    input wire logic        mclk,
    input wire logic        rst_b,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic [9:0]  table_addr_bits,
    input wire logic        code_byte_half_select,
    input wire logic        pulse_gen_on,
    input wire logic        pw_counter_on,
    input wire logic [2:0]  pw_counter_divider,
    input wire logic [8:0]  pw_divide_ratio,
    input wire logic        comparator_on,
    input wire logic [7:0]  comparator_mode_field,
    input wire logic        counter_clock_source,
    input wire logic        core_clock_select
);
    import pcr_pkg::*;
    logic commit;
    assign commit = psel && penable && pready && pwrite;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // outputs trail the register by one cycle, hence the two-cycle look-ahead
    chk_ready_next: assert property (psel && !penable |=> pready)
        else $error("no ready in first access cycle");
    chk_upper_zero: assert property (pready |-> prdata[31:8] == 24'h000000)
        else $error("read data above bit 7 not zero");
    chk_table_low: assert property (commit && paddr == {IDX_TBL_LO, 2'b00} |->
        ##2 table_addr_bits[7:0] == $past(pwdata[7:0], 2)) else $error("table address low");
    chk_half_sel: assert property (commit && paddr == {IDX_TBL_HI, 2'b00} |->
        ##2 code_byte_half_select == $past(pwdata[7], 2)
        && table_addr_bits[9:8] == $past(pwdata[1:0], 2)) else $error("half select");
    chk_pulse_ctl: assert property (commit && paddr == {IDX_PW_CTL, 2'b00} |->
        ##2 {pulse_gen_on, pw_counter_on, pw_counter_divider} == $past(pwdata[4:0], 2))
        else $error("pulse control outputs");
    chk_ratio_map: assert property (pw_divide_ratio ==
        (9'h001 << (4'(pw_counter_divider) + 4'(pw_counter_divider > 3'h4))))
        else $error("divide ratio mismatch");
    chk_mode_gate: assert property (!comparator_on |-> comparator_mode_field == 8'h00)
        else $error("comparator mode while off");
    chk_clock_sel: assert property (commit && paddr == {IDX_SYS_CTL, 2'b00} |->
        ##2 {counter_clock_source, core_clock_select} == $past(pwdata[7:6], 2))
        else $error("clock select outputs");
endmodule : pcr_bank_checker

bind pcr_bank pcr_bank_checker pcr_bank_checker_i (.mclk, .rst_b, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .prdata, .table_addr_bits, .code_byte_half_select,
    .pulse_gen_on, .pw_counter_on, .pw_counter_divider, .pw_divide_ratio, .comparator_on,
    .comparator_mode_field, .counter_clock_source, .core_clock_select);

// >>> pcr_pin_if.sv
// pin-mux interface between bank and pin mux
// assumes one clock domain
`timescale 1ns/1ps
interface pcr_pin_if;
    logic [7:0] p6_data;
    logic [7:0] p6_dir;
    logic [7:0] cmp_sel;
    logic       cmp_on;
    logic       ref_int;
    logic [1:0] neg_chan;
    logic       pulse_on;
    logic       pulse_out;
    logic       cnt_ext;
    logic       cmp_result;
    logic [7:0] p6_out;
    logic [7:0] p6_oe;
    modport bank (output p6_data, p6_dir, cmp_sel, cmp_on, ref_int, neg_chan, pulse_on,
                  pulse_out, cnt_ext, cmp_result, input p6_out, p6_oe);
    modport mux  (input p6_data, p6_dir, cmp_sel, cmp_on, ref_int, neg_chan, pulse_on,
                  pulse_out, cnt_ext, cmp_result, output p6_out, p6_oe);
endinterface : pcr_pin_if

// >>> pcr_pin_mux.sv
// port six pin-mux, combinational
// assumes registered controls from the bank
`timescale 1ns/1ps
module pcr_pin_mux
(
    pcr_pin_if.mux pins
);
    import pcr_pkg::*;

    logic [1:0] mode_a;
    logic       cmp_used;

    always_comb
    begin
        mode_a   = pins.cmp_sel[7:6];
        cmp_used = pins.cmp_on && (mode_a == 2'b01 || mode_a == 2'b10);
        pins.p6_out = pins.p6_data;
        pins.p6_oe  = ~pins.p6_dir;
        // p61: cmp positive input, then pulse output, then port
        if (cmp_used && !pins.ref_int)
        begin
            pins.p6_oe[1] = 1'b0;
        end
        else if (pins.pulse_on)
        begin
            pins.p6_oe[1]  = 1'b1;
            pins.p6_out[1] = pins.pulse_out;
        end
        // p62: cmp negative input a, then counter input, then port
        if (cmp_used && pins.neg_chan == 2'b00)
        begin
            pins.p6_oe[2] = 1'b0;
        end
        else if (pins.cnt_ext)
        begin
            pins.p6_oe[2] = 1'b0;
        end
        // p60 drives comparator output in mode 10
        if (pins.cmp_on && mode_a == 2'b10)
        begin
            pins.p6_oe[0]  = 1'b1;
            pins.p6_out[0] = pins.cmp_result;
        end
    end
endmodule : pcr_pin_mux

// >>> pcr_pkg.sv
// package for the peripheral control register bank
// assumes apb with 32-bit data, one register per aligned word
package pcr_pkg;
    // register indices as printed; byte address is four times the index
    localparam logic [5:0] IDX_INDIRECT  = 6'h00;
    localparam logic [5:0] IDX_RAM_SEL   = 6'h04;
    localparam logic [5:0] IDX_PORT5     = 6'h05;
    localparam logic [5:0] IDX_PORT6     = 6'h06;
    localparam logic [5:0] IDX_TBL_LO    = 6'h07;
    localparam logic [5:0] IDX_TBL_HI    = 6'h08;
    localparam logic [5:0] IDX_PW_CTL    = 6'h0a;
    localparam logic [5:0] IDX_CMP_SEL   = 6'h0b;
    localparam logic [5:0] IDX_CMP_CFG   = 6'h0c;
    localparam logic [5:0] IDX_SYS_CTL   = 6'h0d;
    localparam logic [5:0] IDX_WAKE_CTL  = 6'h0e;
    localparam logic [5:0] IDX_DIR5      = 6'h15;
    localparam logic [5:0] IDX_DIR6      = 6'h16;
    localparam logic [5:0] GPR_FIRST     = 6'h10;
    localparam int         GPR_COUNT     = 48;
    // writable masks
    localparam logic [7:0] MASK_PORT5    = 8'h3f;
    localparam logic [7:0] MASK_TBL_HI   = 8'h83;
    localparam logic [7:0] MASK_PW_CTL   = 8'h1f;
    localparam logic [7:0] MASK_CMP_CFG  = 8'hf7;
    localparam logic [7:0] MASK_SYS_CTL  = 8'he0;
    localparam logic [7:0] MASK_WAKE     = 8'h06;
    // field positions
    localparam int BIT_HALF_SEL    = 7;
    localparam int BIT_PULSE_ON    = 4;
    localparam int BIT_PW_CNT_ON   = 3;
    localparam int BIT_REF_SRC     = 7;
    localparam int BIT_CMP_RESULT  = 3;
    localparam int BIT_CMP_ON      = 2;
    localparam int BIT_CNT_CLK_SRC = 7;
    localparam int BIT_CORE_CLK    = 6;
    localparam int BIT_IDLE        = 5;
    localparam int BIT_CMP_WAKE    = 2;
    localparam int BIT_PORT_WAKE   = 1;
    // reset values
    localparam logic [7:0] RST_REG       = 8'h00;
    localparam logic [7:0] RST_DIR       = 8'hff;
    localparam logic [31:0] RD_ZERO      = 32'h0000_0000;
endpackage : pcr_pkg

// >>> tb_pcr_bank.sv
// self-checking bench for the control register bank over apb
// assumes the checker is bound separately; pins driven directly
`timescale 1ns/1ps
module tb_pcr_bank;
    import pcr_pkg::*;
    logic mclk, rst_b, psel, penable, pwrite, cmp_raw, pdi, plev, rerr;
    logic [7:0]  paddr, p6_in, p6_out, p6_oe;
    logic [31:0] pwdata, prdata, rdat;
    logic [5:0]  p5_in;
    logic [2:0]  seen;
    logic [5:0]  p5_out, p5_oe;
    logic [8:0]  ratio_o;
    logic [2:0]  rlev;
    logic [1:0]  nch;
    logic        rsel, cnt_ext;
    logic pready, pslverr, idle_entered, sleep_entered, wake_request;
    int mismatches, checks_done, cyc;
    logic [5:0] idx_t [8] = '{IDX_RAM_SEL, IDX_TBL_LO, IDX_TBL_HI, IDX_PW_CTL,
                               IDX_CMP_SEL, IDX_CMP_CFG, IDX_SYS_CTL, IDX_WAKE_CTL};
    logic [7:0] msk_t [8] = '{8'hff, 8'hff, MASK_TBL_HI, MASK_PW_CTL, 8'hff, MASK_CMP_CFG,
                              MASK_SYS_CTL, MASK_WAKE};
    logic [8:0] div_t [8] = '{9'h001, 9'h002, 9'h004, 9'h008, 9'h010, 9'h040, 9'h080,
                              9'h100};
    pcr_bank pcr_bank_i (.mclk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
        .prdata, .pslverr, .p5_in, .p5_out, .p5_oe, .p6_in, .p6_out, .p6_oe, .cmp_raw,
        .pulse_level(plev), .cnt_ext_src(cnt_ext), .power_down_instruction(pdi),
        .table_addr_bits(), .code_byte_half_select(), .pulse_gen_on(), .pw_counter_on(),
        .pw_counter_divider(), .pw_divide_ratio(ratio_o), .comparator_on(),
        .comparator_mode_field(), .reference_source_sel(rsel), .reference_level_field(rlev),
        .negative_input_channel(nch), .counter_clock_source(), .core_clock_select(),
        .idle_entered, .sleep_entered, .wake_request);
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_of_test
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    // request held until the edge that samples pready high
    task automatic apb(input logic w, input logic [5:0] i, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {i, 2'b00};
        pwdata  <= {24'h000000, d};
        @(posedge mclk);
        penable <= 1'b1;
        @(negedge mclk);
        while (pready !== 1'b1 && n < 16)
        begin
            n++;
            @(negedge mclk);
        end
        @(posedge mclk);
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n == 16)
            cmp(32'h0, 32'h1);
    endtask : apb
    task automatic wr(input logic [5:0] i, input logic [7:0] d);
        apb(1'b1, i, d);
    endtask : wr
    task automatic rd(input logic [5:0] i, input logic [7:0] e);
        apb(1'b0, i, 8'h00);
        cmp(rdat, {24'h000000, e});
    endtask : rd
    // pulses are one cycle wide, so every negedge is inspected
    task automatic watch;
        seen = 3'b000;
        repeat (12)
        begin
            @(negedge mclk);
            seen = seen | {idle_entered, sleep_entered, wake_request};
        end
    endtask : watch
    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            mismatches++;
            end_of_test();
        end
    end
    initial
    begin
        {rst_b, psel, penable, pwrite, cmp_raw, pdi, plev, cnt_ext} = 8'h00;
        {paddr, pwdata, p5_in, p6_in} = '0;
        repeat (20) @(posedge mclk);
        rst_b <= 1'b1;
        foreach (idx_t[k]) rd(idx_t[k], RST_REG);
        rd(IDX_DIR6, RST_DIR);
        foreach (idx_t[k])
        begin
            wr(idx_t[k], 8'hff);
            rd(idx_t[k], msk_t[k]);
            wr(idx_t[k], 8'h00);
        end
        for (int d = 0; d < 8; d++)
        begin
            wr(IDX_PW_CTL, 8'(d) | 8'h18);
            rd(IDX_PW_CTL, 8'(d) | 8'h18);
            cmp({23'h0, ratio_o}, {23'h0, div_t[d]});
        end
        plev <= 1'b1;
        wr(IDX_DIR6, 8'h02);
        wr(IDX_PORT6, 8'ha5);
        rd(IDX_PORT6, 8'ha5);
        cmp({16'h0, p6_oe, p6_out}, 32'h0000ffa7);
        wr(IDX_PW_CTL, 8'h00);
        rd(IDX_PW_CTL, 8'h00);
        cmp({24'h0, p6_oe}, 32'h000000fd);
        wr(IDX_DIR5, 8'h00);
        wr(IDX_PORT5, 8'hff);
        rd(IDX_PORT5, 8'h3f);
        wr(IDX_DIR6, 8'hff);
        p6_in <= 8'h3c;
        watch();
        cmp({29'h0, seen}, 32'h0);
        wr(IDX_WAKE_CTL, 8'h02);
        p6_in <= 8'hc3;
        watch();
        cmp({29'h0, seen}, 32'h1);
        rd(IDX_PORT6, 8'hc3);
        wr(IDX_CMP_CFG, 8'h04);
        wr(IDX_CMP_SEL, 8'h80);
        wr(IDX_WAKE_CTL, 8'h04);
        cmp_raw <= 1'b1;
        watch();
        cmp({29'h0, seen}, 32'h1);
        rd(IDX_CMP_CFG, 8'h0c);
        wr(IDX_DIR6, 8'h00);
        wr(IDX_PW_CTL, 8'h10);
        rd(IDX_PW_CTL, 8'h10);
        cmp({16'h0, p6_oe, p6_out}, 32'h0000f9a5);
        wr(IDX_CMP_SEL, 8'h40);
        cnt_ext <= 1'b1;
        wr(IDX_CMP_CFG, 8'hd7);
        rd(IDX_CMP_CFG, 8'hdf);
        cmp({16'h0, p6_oe, p6_out}, 32'h0000fba7);
        cmp({20'h0, p5_oe, p5_out}, 32'h00000fbf);
        cmp({26'h0, rsel, rlev, nch}, 32'h00000037);
        wr(IDX_SYS_CTL, 8'h20);
        pdi <= 1'b1;
        watch();
        cmp({29'h0, seen}, 32'h4);
        pdi <= 1'b0;
        wr(IDX_SYS_CTL, 8'h00);
        pdi <= 1'b1;
        watch();
        cmp({29'h0, seen}, 32'h2);
        pdi <= 1'b0;
        wr(IDX_RAM_SEL, 8'h3f);
        wr(IDX_INDIRECT, 8'h5a);
        rd(IDX_INDIRECT, 8'h5a);
        rd(IDX_RAM_SEL, 8'h3f);
        wr(IDX_RAM_SEL, 8'hc7);
        wr(IDX_INDIRECT, 8'h33);
        rd(IDX_TBL_LO, 8'h33);
        rd(IDX_RAM_SEL, 8'hc7);
        apb(1'b0, 6'h09, 8'h00);
        cmp({rdat[31:1], rerr}, 32'h1);
        end_of_test();
    end
endmodule : tb_pcr_bank
